//--- hdl/ups_consts.svh
`ifndef UPS_CONSTS_SVH
`define UPS_CONSTS_SVH

// character and buffer shape
`define UPS_DATA_W 8
`define UPS_FIFO_DEPTH 16

// clock
`define UPS_CLK_PERIOD_NS 10
`define UPS_NS_PER_MS 1000000
`define UPS_NS_PER_US 1000

// wake-up time of port and module, ms
`define UPS_WAKE_MS 20
`define UPS_WAKE_CYC (`UPS_WAKE_MS * (`UPS_NS_PER_MS / `UPS_CLK_PERIOD_NS))

// frame period used by the inactivity timeout, us
`define UPS_FRAME_US 4615
`define UPS_FRAME_CYC (`UPS_FRAME_US * (`UPS_NS_PER_US / `UPS_CLK_PERIOD_NS))

// port-off time between periodic wake windows, ms
`define UPS_CYCLE_OFF_MS 2500
`define UPS_CYCLE_OFF_CYC \
  (`UPS_CYCLE_OFF_MS * (`UPS_NS_PER_MS / `UPS_CLK_PERIOD_NS))

// inactivity timeout in frames
`define UPS_TMO_W 16
`define UPS_TMO_MIN 16'h0028
`define UPS_TMO_MAX 16'hfde8
`define UPS_TMO_DEF 16'h07d0

// cycle counter width
`define UPS_CNT_W 32

`endif

//--- hdl/ups_pkg.sv
package ups_pkg;

  typedef logic [7:0] ups_char_t;

  typedef enum logic [1:0] {
    UPS_CFG_ALWAYS = 2'b00,
    UPS_CFG_CYCLIC = 2'b01,
    UPS_CFG_RTS = 2'b10,
    UPS_CFG_DTR = 2'b11
  } ups_cfg_t;

  typedef enum logic [1:0] {
    UPS_ST_IDLE = 2'b00,
    UPS_ST_WAKING = 2'b01,
    UPS_ST_WINDOW = 2'b10,
    UPS_ST_ACTIVE = 2'b11
  } ups_state_t;

endpackage

//--- hdl/ups_link_if.sv
interface ups_link_if;
  // host to device character strobe
  logic h2d_valid;
  ups_pkg::ups_char_t h2d_data;
  // device to host character strobe
  logic d2h_valid;
  ups_pkg::ups_char_t d2h_data;
  // modem lines, 1 = ON
  logic rts;
  logic dtr;
  logic cts;

  modport dev (
    input h2d_valid,
    input h2d_data,
    input rts,
    input dtr,
    output d2h_valid,
    output d2h_data,
    output cts
  );

  modport host (
    output h2d_valid,
    output h2d_data,
    output rts,
    output dtr,
    input d2h_valid,
    input d2h_data,
    input cts
  );
endinterface

//--- hdl/ups_dev_end.sv
// Function
// - config 0: never idle, port always enabled
// - config 1: cycle active/idle with port enable
// - config 2: rts governs port and idle
// - config 3: dtr governs port and idle
// - idle whenever nothing keeps module active
// - config 0, flow on, rts on: lossless
// - config 0, flow on, rts off: host holds
// - flow on, rts off: device buffers transmit
// - config 1, flow on: host waits for active
// - config 1, flow off: first char wakes, dropped
// - config 2 with flow control is refused
// - config 2, rts off: chars dropped, optional wake
// - config 3: dtr off drops host chars
// - flow off: transmit without waiting for host
// - config 0: cts always asserted
// - config 2 rts on: wake after 20 ms
// - config 1 inactivity timeout 40..65000 frames
// - config 1, flow on: cts follows port

`include "ups_consts.svh"

////////////////////////////////////////////////////////////////////////////
// transmit buffer

module ups_fifo #(
  parameter int unsigned WIDTH = `UPS_DATA_W,
  parameter int unsigned DEPTH = `UPS_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;

  wire full = (wr_reg[AW] != rd_reg[AW]) &&
              (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = (wr_reg == rd_reg);
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_reg[AW-1:0]];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= i_in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// device end: power-save gating of the serial port

module ups_dev_end #(
  parameter int unsigned WAKE_CYC = `UPS_WAKE_CYC,
  parameter int unsigned FRAME_CYC = `UPS_FRAME_CYC,
  parameter int unsigned CYCLE_OFF_CYC = `UPS_CYCLE_OFF_CYC,
  parameter bit WAKE_ON_CHAR = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  ups_link_if.dev link,
  input wire logic [1:0] i_power_save_config,
  input wire logic i_flow_control_on_select,
  input wire logic [`UPS_TMO_W-1:0] i_inact_frames,
  input wire logic i_busy,
  input wire logic i_tx_valid,
  input wire ups_pkg::ups_char_t i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output ups_pkg::ups_char_t o_rx_data,
  output logic o_rx_dropped,
  output logic o_port_enabled,
  output logic o_idle,
  output logic o_cfg_refused
);
  ups_pkg::ups_state_t state_reg;
  ups_pkg::ups_state_t state_next;
  ups_pkg::ups_cfg_t cfg_prev_reg;
  logic [`UPS_CNT_W-1:0] cnt_reg;
  logic [`UPS_CNT_W-1:0] cnt_next;
  logic [`UPS_CNT_W-1:0] pre_reg;
  logic [`UPS_TMO_W-1:0] tmo_reg;
  logic wake_char_reg;
  logic wake_char_next;
  logic entry_load;
  logic hold_prev_reg;
  logic rx_valid_reg;
  ups_pkg::ups_char_t rx_data_reg;
  logic rx_drop_reg;
  logic idle_reg;
  logic d2h_valid_reg;
  ups_pkg::ups_char_t d2h_data_reg;
  logic fifo_valid;
  ups_pkg::ups_char_t fifo_data;

  //////////////////////////////////////////////////////////////////////////
  // configuration decode

  wire cfg_refused = (i_power_save_config == 2'b10) &&
                     i_flow_control_on_select;
  wire ups_pkg::ups_cfg_t cfg = cfg_refused ? ups_pkg::UPS_CFG_ALWAYS :
      ups_pkg::ups_cfg_t'(i_power_save_config);
  wire cfg_always = (cfg == ups_pkg::UPS_CFG_ALWAYS);
  wire cfg_cyclic = (cfg == ups_pkg::UPS_CFG_CYCLIC);
  wire cfg_rts = (cfg == ups_pkg::UPS_CFG_RTS);
  wire cfg_dtr = (cfg == ups_pkg::UPS_CFG_DTR);
  wire cfg_changed = (cfg != cfg_prev_reg);
  wire flow_on = i_flow_control_on_select && !cfg_rts;

  // zero selects the default timeout, others clamp to the legal range
  wire [`UPS_TMO_W-1:0] tmo_frames =
      (i_inact_frames == '0) ? `UPS_TMO_DEF :
      (i_inact_frames < `UPS_TMO_MIN) ? `UPS_TMO_MIN :
      (i_inact_frames > `UPS_TMO_MAX) ? `UPS_TMO_MAX :
      i_inact_frames;

  //////////////////////////////////////////////////////////////////////////
  // activity and gating terms

  wire line_hold = (cfg_rts && link.rts) ||
                   (cfg_dtr && link.dtr);
  wire hold_fall = hold_prev_reg && !line_hold;
  wire hold_any = line_hold || fifo_valid;
  wire port_en = (state_reg == ups_pkg::UPS_ST_ACTIVE) ||
                 (state_reg == ups_pkg::UPS_ST_WINDOW);
  wire rx_ok = link.h2d_valid && port_en &&
               (!cfg_dtr || link.dtr);
  wire rx_drop = link.h2d_valid && !rx_ok;
  wire tmo_load = (rx_ok && (cfg_cyclic || cfg_rts)) ||
                  entry_load;
  wire frame_tick = (pre_reg == `UPS_CNT_W'(FRAME_CYC - 1));
  wire wake_done = (cnt_reg >= `UPS_CNT_W'(WAKE_CYC - 1));
  wire off_done = (cnt_reg >= `UPS_CNT_W'(CYCLE_OFF_CYC - 1));
  wire tx_go = port_en && (!flow_on || link.rts);

  //////////////////////////////////////////////////////////////////////////
  // power-save state machine

  always_comb begin
    state_next = state_reg;
    wake_char_next = wake_char_reg;
    entry_load = 1'b0;
    if (cfg_always) begin
      state_next = ups_pkg::UPS_ST_ACTIVE;
      wake_char_next = 1'b0;
    end else if (cfg_changed) begin
      state_next = ups_pkg::UPS_ST_IDLE;
      wake_char_next = 1'b0;
    end else begin
      case (state_reg)
        ups_pkg::UPS_ST_IDLE: begin
          if (hold_any) begin
            state_next = ups_pkg::UPS_ST_WAKING;
          end else if (rx_drop && cfg_cyclic && !flow_on) begin
            state_next = ups_pkg::UPS_ST_WAKING;
            wake_char_next = 1'b1;
          end else if (rx_drop && cfg_rts && WAKE_ON_CHAR) begin
            state_next = ups_pkg::UPS_ST_WAKING;
            wake_char_next = 1'b1;
          end else if (cfg_cyclic && off_done) begin
            state_next = ups_pkg::UPS_ST_WINDOW;
          end
        end
        ups_pkg::UPS_ST_WAKING: begin
          if (wake_done) begin
            state_next = ups_pkg::UPS_ST_ACTIVE;
            entry_load = cfg_cyclic || wake_char_reg;
            wake_char_next = 1'b0;
          end
        end
        ups_pkg::UPS_ST_WINDOW: begin
          if (rx_ok || hold_any) begin
            state_next = ups_pkg::UPS_ST_ACTIVE;
          end else if (wake_done) begin
            state_next = ups_pkg::UPS_ST_IDLE;
          end
        end
        ups_pkg::UPS_ST_ACTIVE: begin
          if (!hold_any && tmo_reg == '0 && !tmo_load) begin
            state_next = ups_pkg::UPS_ST_IDLE;
          end
        end
        default: begin
          state_next = ups_pkg::UPS_ST_IDLE;
        end
      endcase
    end
    cnt_next = (state_next != state_reg) ? '0 : cnt_reg + 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ups_pkg::UPS_ST_ACTIVE;
      cfg_prev_reg <= ups_pkg::UPS_CFG_ALWAYS;
      cnt_reg <= '0;
      wake_char_reg <= 1'b0;
      hold_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cfg_prev_reg <= cfg;
      cnt_reg <= cnt_next;
      wake_char_reg <= wake_char_next;
      hold_prev_reg <= line_hold;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // inactivity timeout in frames, restarted by each character received in config 1 or 2

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_reg <= '0;
      tmo_reg <= '0;
    end else begin
      pre_reg <= frame_tick ? '0 : pre_reg + 1'b1;
      if (tmo_load) begin
        tmo_reg <= tmo_frames;
      end else if (hold_fall || cfg_changed) begin
        tmo_reg <= '0;
      end else if (frame_tick && tmo_reg != '0) begin
        tmo_reg <= tmo_reg - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive path and status

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      rx_drop_reg <= 1'b0;
      idle_reg <= 1'b0;
    end else begin
      rx_valid_reg <= rx_ok;
      rx_drop_reg <= rx_drop;
      if (rx_ok) begin
        rx_data_reg <= link.h2d_data;
      end
      idle_reg <= (state_next == ups_pkg::UPS_ST_IDLE) && !i_busy;
    end
  end

  assign o_rx_valid = rx_valid_reg;
  assign o_rx_data = rx_data_reg;
  assign o_rx_dropped = rx_drop_reg;
  assign o_idle = idle_reg;
  assign o_port_enabled = port_en;
  assign o_cfg_refused = cfg_refused;

  //////////////////////////////////////////////////////////////////////////
  // transmit path

  ups_fifo #(
    .WIDTH(`UPS_DATA_W),
    .DEPTH(`UPS_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .i_in_data(i_tx_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(tx_go),
    .o_out_data(fifo_data)
  );

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      d2h_valid_reg <= 1'b0;
      d2h_data_reg <= 8'h00;
    end else begin
      d2h_valid_reg <= fifo_valid && tx_go;
      if (fifo_valid && tx_go) begin
        d2h_data_reg <= fifo_data;
      end
    end
  end

  assign link.d2h_valid = d2h_valid_reg;
  assign link.d2h_data = d2h_data_reg;
  // config 0 holds cts on; others show the port enable
  assign link.cts = cfg_always || port_en;
endmodule

//--- hdl/ups_host_end.sv
`include "ups_consts.svh"

////////////////////////////////////////////////////////////////////////////
// host end: terminal side of the serial link

module ups_host_end (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  ups_link_if.host link,
  input wire logic [1:0] i_power_save_config,
  input wire logic i_flow_control_on_select,
  input wire logic i_rts_on,
  input wire logic i_dtr_on,
  input wire logic i_tx_valid,
  input wire ups_pkg::ups_char_t i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output ups_pkg::ups_char_t o_rx_data,
  input wire logic i_rx_ready,
  output logic o_rx_lost
);
  logic h2d_valid_reg;
  ups_pkg::ups_char_t h2d_data_reg;
  logic rts_reg;
  logic dtr_reg;
  logic rx_valid_reg;
  ups_pkg::ups_char_t rx_data_reg;
  logic rx_lost_reg;

  // flow control is never combined with rts-governed power save
  wire flow_on = i_flow_control_on_select &&
                 (i_power_save_config != 2'b10);
  // with flow control the host holds characters until cts and its own rts
  wire send_ok = !flow_on || (link.cts && rts_reg);
  wire send = i_tx_valid && send_ok;
  wire rx_take = link.d2h_valid && i_rx_ready;

  assign o_tx_ready = send_ok;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      h2d_valid_reg <= 1'b0;
      h2d_data_reg <= 8'h00;
      rts_reg <= 1'b0;
      dtr_reg <= 1'b0;
    end else begin
      h2d_valid_reg <= send;
      if (send) begin
        h2d_data_reg <= i_tx_data;
      end
      rts_reg <= i_rts_on;
      dtr_reg <= i_dtr_on;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      rx_lost_reg <= 1'b0;
    end else begin
      rx_valid_reg <= rx_take;
      rx_lost_reg <= link.d2h_valid && !i_rx_ready;
      if (rx_take) begin
        rx_data_reg <= link.d2h_data;
      end
    end
  end

  assign link.h2d_valid = h2d_valid_reg;
  assign link.h2d_data = h2d_data_reg;
  assign link.rts = rts_reg;
  assign link.dtr = dtr_reg;
  assign o_rx_valid = rx_valid_reg;
  assign o_rx_data = rx_data_reg;
  assign o_rx_lost = rx_lost_reg;
endmodule

//--- test/ups_link_props.sv
////////////////////////////////////////////////////////////////////////////
// link checker: watches both ends across the shared link

module ups_link_props (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_power_save_config,
  input wire logic i_flow_control_on_select,
  input wire logic i_busy,
  input wire logic o_port_enabled,
  input wire logic o_idle,
  input wire logic o_rx_valid,
  input wire ups_pkg::ups_char_t o_rx_data,
  input wire logic o_rx_dropped,
  input wire logic h2d_valid,
  input wire ups_pkg::ups_char_t h2d_data,
  input wire logic d2h_valid,
  input wire logic rts,
  input wire logic dtr,
  input wire logic cts
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int WAKE_SPAN = 30;

  // a refused setting runs as always-on, so cts stays up
  wire refused = (i_power_save_config == 2'h2) && i_flow_control_on_select;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // wake-up steps after a request line rises

  sequence rts_rise;
    $rose(rts) && !o_port_enabled && i_power_save_config == 2'h2 &&
      !i_flow_control_on_select;
  endsequence

  sequence port_held_off;
    !o_port_enabled [*8];
  endsequence

  sequence port_comes_up;
    port_held_off ##[1:WAKE_SPAN] o_port_enabled;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  cfg0_cts_a: assert property (
    i_power_save_config == 2'h0 |-> cts)
    else $error("clear-to-send low in always-on mode");

  cfg0_port_a: assert property (
    i_power_save_config == 2'h0 && $past(i_power_save_config) == 2'h0
      |-> o_port_enabled && !o_idle)
    else $error("port off or idle in always-on mode");

  cts_port_a: assert property (
    i_power_save_config != 2'h0 |-> cts == (o_port_enabled || refused))
    else $error("clear-to-send differs from port enable");

  rx_accept_a: assert property (
    h2d_valid && o_port_enabled && (i_power_save_config != 2'h3 || dtr)
      |=> o_rx_valid && !o_rx_dropped && o_rx_data == $past(h2d_data))
    else $error("enabled port did not deliver host char");

  dtr_drop_a: assert property (
    i_power_save_config == 2'h3 && !dtr && h2d_valid
      |=> o_rx_dropped && !o_rx_valid)
    else $error("host char kept while terminal not ready");

  flow_hold_a: assert property (
    (i_flow_control_on_select && !rts) [*2] |-> !d2h_valid)
    else $error("device sent while host not ready");

  rts_wake_a: assert property (
    rts_rise |-> port_comes_up)
    else $error("wake-up after request rise out of bounds");

  rts_keep_a: assert property (
    i_power_save_config == 2'h2 && !i_flow_control_on_select && rts &&
      o_port_enabled && $stable(i_power_save_config) &&
      $stable(i_flow_control_on_select) |=> o_port_enabled)
    else $error("port dropped while request held on");

  busy_idle_a: assert property (
    i_busy |=> !o_idle)
    else $error("idle entered while busy");

endmodule

//--- test/uart_power_save_gating_test.sv
module uart_power_save_gating_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_ref_clk;
  logic i_rst;
  logic [1:0] i_power_save_config;
  logic i_flow_control_on_select;
  logic [15:0] i_inact_frames;
  logic i_busy;
  logic i_tx_valid;
  ups_pkg::ups_char_t i_tx_data;
  logic o_tx_ready;
  logic o_rx_valid;
  ups_pkg::ups_char_t o_rx_data;
  logic o_rx_dropped;
  logic o_port_enabled;
  logic o_idle;
  logic o_cfg_refused;
  logic h_rts;
  logic h_dtr;
  logic h_tx_valid;
  ups_pkg::ups_char_t h_tx_data;
  logic h_tx_ready;
  logic h_rx_valid;
  ups_pkg::ups_char_t h_rx_data;
  logic h_rx_ready;
  logic h_rx_lost;
  int num_errors = 0;
  int checks_done = 0;
  int drops = 0;
  int lost = 0;
  int n;
  int i;
  ups_pkg::ups_char_t dq[$];
  ups_pkg::ups_char_t hq[$];

  ups_link_if lnk ();

  ups_dev_end #(.WAKE_CYC(20), .FRAME_CYC(10), .CYCLE_OFF_CYC(50))
  u_ups_dev_end (
    .i_ref_clk, .i_rst, .link(lnk), .i_power_save_config,
    .i_flow_control_on_select, .i_inact_frames, .i_busy, .i_tx_valid,
    .i_tx_data, .o_tx_ready, .o_rx_valid, .o_rx_data, .o_rx_dropped,
    .o_port_enabled, .o_idle, .o_cfg_refused
  );

  ups_host_end u_ups_host_end (
    .i_ref_clk, .i_rst, .link(lnk), .i_power_save_config,
    .i_flow_control_on_select, .i_rts_on(h_rts), .i_dtr_on(h_dtr),
    .i_tx_valid(h_tx_valid), .i_tx_data(h_tx_data), .o_tx_ready(h_tx_ready),
    .o_rx_valid(h_rx_valid), .o_rx_data(h_rx_data), .i_rx_ready(h_rx_ready),
    .o_rx_lost(h_rx_lost)
  );

  ups_link_props u_props (
    .i_ref_clk, .i_rst, .i_power_save_config, .i_flow_control_on_select,
    .i_busy, .o_port_enabled, .o_idle, .o_rx_valid, .o_rx_data, .o_rx_dropped,
    .h2d_valid(lnk.h2d_valid), .h2d_data(lnk.h2d_data),
    .d2h_valid(lnk.d2h_valid), .rts(lnk.rts), .dtr(lnk.dtr), .cts(lnk.cts)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, monitors, helpers

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    if (o_rx_valid === 1'b1) dq.push_back(o_rx_data);
    if (o_rx_dropped === 1'b1) drops++;
    if (h_rx_valid === 1'b1) hq.push_back(h_rx_data);
    if (h_rx_lost === 1'b1) lost++;
  end

  task automatic tick(input int c);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // valid stays up so calls can run back to back; stop() lowers it
  task automatic push(input bit dev, input ups_pkg::ups_char_t ch);
    int w;
    w = 0;
    if (dev) begin
      i_tx_valid = 1'b1;
      i_tx_data = ch;
    end else begin
      h_tx_valid = 1'b1;
      h_tx_data = ch;
    end
    while ((dev ? o_tx_ready : h_tx_ready) !== 1'b1 && w < 200) begin
      tick(1);
      w++;
    end
    if (w == 200) num_errors++;
    tick(1);
  endtask

  task automatic stop();
    i_tx_valid = 1'b0;
    h_tx_valid = 1'b0;
  endtask

  task automatic setm(input logic [1:0] c, input logic f, r, d);
    i_power_save_config = c;
    i_flow_control_on_select = f;
    h_rts = r;
    h_dtr = d;
    tick(4);
  endtask

  task automatic wait_port(input logic lvl, output int cnt);
    cnt = 0;
    while (o_port_enabled !== lvl && cnt < 1000) begin
      tick(1);
      cnt++;
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(5000 * 10);
    num_errors++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // tests

  initial begin
    i_rst = 1'b1;
    i_power_save_config = 2'h0;
    i_flow_control_on_select = 1'b1;
    // below the minimum: clamps to 40 frames
    i_inact_frames = 16'h0005;
    i_busy = 1'b0;
    i_tx_valid = 1'b0;
    i_tx_data = 8'h00;
    h_rts = 1'b1;
    h_dtr = 1'b1;
    h_tx_valid = 1'b0;
    h_tx_data = 8'h00;
    h_rx_ready = 1'b1;
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    // always on, flow on, both directions
    setm(2'h0, 1'b1, 1'b1, 1'b1);
    chk("port", 16'(o_port_enabled), 16'h0001);
    chk("cts", 16'(lnk.cts), 16'h0001);
    for (i = 0; i < 3; i++) push(1'b0, 8'(8'ha0 + i));
    stop();
    for (i = 0; i < 3; i++) push(1'b1, 8'(8'hb0 + i));
    stop();
    tick(8);
    for (i = 0; i < 3; i++) begin
      chk("drx", dq.pop_front(), 16'(8'ha0 + i));
      chk("hrx", hq.pop_front(), 16'(8'hb0 + i));
    end
    // host not ready: fill the fifo until it refuses, then drain
    setm(2'h0, 1'b1, 1'b0, 1'b1);
    chk("h_ready", 16'(h_tx_ready), 16'h0000);
    for (i = 0; i < 16; i++) push(1'b1, 8'(8'hc0 + i));
    stop();
    chk("full", 16'(o_tx_ready), 16'h0000);
    tick(10);
    chk("held", 16'(hq.size()), 16'h0000);
    setm(2'h0, 1'b1, 1'b1, 1'b1);
    tick(30);
    for (i = 0; i < 16; i++) begin
      chk("drain", hq.pop_front(), 16'(8'hc0 + i));
    end
    // flow off, host not ready: char lost
    setm(2'h0, 1'b0, 1'b0, 1'b1);
    h_rx_ready = 1'b0;
    push(1'b1, 8'hd5);
    stop();
    tick(6);
    chk("lost", 16'(lost), 16'h0001);
    h_rx_ready = 1'b1;
    // cyclic mode, flow off
    setm(2'h1, 1'b0, 1'b1, 1'b1);
    chk("c1port", 16'(o_port_enabled), 16'h0000);
    chk("c1idle", 16'(o_idle), 16'h0001);
    i_busy = 1'b1;
    tick(2);
    chk("busy", 16'(o_idle), 16'h0000);
    i_busy = 1'b0;
    push(1'b0, 8'he1);
    stop();
    tick(2);
    chk("wdrop", 16'(drops), 16'h0001);
    tick(25);
    chk("woke", 16'(o_port_enabled), 16'h0001);
    push(1'b0, 8'he2);
    stop();
    tick(2);
    chk("wrx", dq.pop_front(), 16'h00e2);
    wait_port(1'b0, n);
    chk("tmo", 16'(n >= 380 && n <= 412), 16'h0001);
    wait_port(1'b1, n);
    chk("off", 16'(n >= 45 && n <= 56), 16'h0001);
    wait_port(1'b0, n);
    chk("window", 16'(n >= 17 && n <= 23), 16'h0001);
    // request-governed mode
    setm(2'h2, 1'b1, 1'b1, 1'b1);
    chk("refuse", 16'(o_cfg_refused), 16'h0001);
    setm(2'h2, 1'b0, 1'b0, 1'b1);
    chk("r_off", 16'(o_port_enabled), 16'h0000);
    setm(2'h2, 1'b0, 1'b1, 1'b1);
    chk("r_wake", 16'(o_port_enabled), 16'h0000);
    tick(25);
    chk("r_on", 16'(o_port_enabled), 16'h0001);
    push(1'b0, 8'hf1);
    stop();
    tick(2);
    chk("r_rx", dq.pop_front(), 16'h00f1);
    setm(2'h2, 1'b0, 1'b0, 1'b1);
    push(1'b0, 8'hf2);
    stop();
    tick(2);
    chk("r_drop", 16'(drops), 16'h0002);
    // terminal-ready-governed mode
    setm(2'h3, 1'b0, 1'b1, 1'b0);
    chk("t_off", 16'(o_port_enabled), 16'h0000);
    push(1'b0, 8'h91);
    stop();
    tick(2);
    chk("t_drop", 16'(drops), 16'h0003);
    setm(2'h3, 1'b1, 1'b1, 1'b1);
    tick(25);
    chk("t_on", 16'(o_port_enabled), 16'h0001);
    push(1'b0, 8'h92);
    stop();
    tick(2);
    chk("t_rx", dq.pop_front(), 16'h0092);
    // cyclic mode, flow on: host holds its char until the port opens
    setm(2'h1, 1'b1, 1'b1, 1'b1);
    chk("c_hold", 16'(h_tx_ready), 16'h0000);
    push(1'b0, 8'h93);
    stop();
    tick(2);
    chk("c_rx", dq.pop_front(), 16'h0093);
    end_of_test();
  end

endmodule
